// File: logic/ctu_map.vh
// Constants for the four-channel counter/timer unit
`ifndef CTU_MAP_VH
`define CTU_MAP_VH

// ****************************************************************
// Channel control word fields
// ****************************************************************
`define CTU_CW_IRQ_EN 7
`define CTU_CW_COUNTER 6
`define CTU_CW_DIV256 5
`define CTU_CW_RISING 4
`define CTU_CW_TRIG_START 3
`define CTU_CW_TC_FOLLOWS 2
`define CTU_CW_SW_RESET 1
`define CTU_CW_IS_CTRL 0

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define CTU_CTRL_RST 8'h00
`define CTU_TC_RST 8'h00
`define CTU_VEC_RST 5'h00
`define CTU_NUM_CH 4
`define CTU_NUM_ZC 3

// ****************************************************************
// Prescaler terminal counts
// ****************************************************************
`define CTU_PS_LAST_16 8'h0f
`define CTU_PS_LAST_256 8'hff

`endif

// File: logic/ctu_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ctu_sync (
  clk,
  srst,
  async_in,
  level_ff
);
  input wire clk;
  input wire srst;
  input wire async_in;
  output reg level_ff;

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // Level changes only once stages two and three agree
  always @(posedge clk) begin
    if (srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
endmodule

// File: logic/ctu_prescale.v
// Per-channel prescaler dividing the system clock by 16 or 256
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_prescale (
  clk,
  srst,
  clr,
  div256,
  tick_ff
);
  input wire clk;
  input wire srst;
  input wire clr;
  input wire div256;
  output reg tick_ff;

  reg [7:0] ps_ff;
  wire [7:0] last;

  assign last = div256 ? `CTU_PS_LAST_256 : `CTU_PS_LAST_16;

  // One tick per 16 or 256 system clocks
  always @(posedge clk) begin
    if (srst || clr) begin
      ps_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (ps_ff == last) begin
      ps_ff <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      ps_ff <= ps_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end
endmodule

// File: logic/ctu_top.v
// Four-channel counter/timer unit with daisy-chain vectored interrupts
`timescale 1ns/1ps
`include "ctu_map.vh"

// Summary of operation
// - Four independent channels numbered zero to three
// - Timer prescaler divides by 16 or 256
// - Host reads live down-counter without disturbing it
// - Zero count reloads time constant automatically
// - Selected trigger edge can start the timer
// - Only channels zero to two have pulse outputs
// - One vector, channel number inserted per channel
// - Channel zero has highest interrupt priority
// - Built-in daisy-chain vectored interrupt logic
// - System clock drives prescaler in timer mode
// - Two select inputs choose the addressed channel
// - Control word bit meanings, bit zero set
// - New constant waits for current count to finish
// - Zero count drives a high output pulse
module ctu_top (
  clk,
  srst,
  chan_select_first,
  chan_select_second,
  wr_stb,
  wr_data,
  rd_stb,
  rd_data_ff,
  rd_valid_ff,
  count_trigger_input,
  zero_count_pulse_out_ff,
  int_enable_in,
  int_enable_out_ff,
  int_req_n_ff,
  int_ack,
  int_vector_ff,
  int_vector_valid_ff,
  int_return
);
  input wire clk;
  input wire srst;
  input wire chan_select_first;
  input wire chan_select_second;
  input wire wr_stb;
  input wire [7:0] wr_data;
  input wire rd_stb;
  output reg [7:0] rd_data_ff;
  output reg rd_valid_ff;
  input wire [3:0] count_trigger_input;
  output reg [2:0] zero_count_pulse_out_ff;
  input wire int_enable_in;
  output reg int_enable_out_ff;
  output reg int_req_n_ff;
  input wire int_ack;
  output reg [7:0] int_vector_ff;
  output reg int_vector_valid_ff;
  input wire int_return;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Lowest set bit index; bit 2 flags an empty vector
  function [2:0] ctu_first;
    input [3:0] v;
    begin
      if (v[0]) begin
        ctu_first = 3'h0;
      end else if (v[1]) begin
        ctu_first = 3'h1;
      end else if (v[2]) begin
        ctu_first = 3'h2;
      end else if (v[3]) begin
        ctu_first = 3'h3;
      end else begin
        ctu_first = 3'h4;
      end
    end
  endfunction

  function [3:0] ctu_onehot;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: ctu_onehot = 4'h1;
        3'h1: ctu_onehot = 4'h2;
        3'h2: ctu_onehot = 4'h4;
        3'h3: ctu_onehot = 4'h8;
        default: ctu_onehot = 4'h0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Channel addressing
  // ****************************************************************
  wire [1:0] chan_sel;
  wire [3:0] wr_hit;
  wire [31:0] cnt_all;
  wire [3:0] zero_ev;
  wire [3:0] irq_en;
  reg [4:0] vec_hi_ff;
  wire [3:0] tc_wait;
  wire [3:0] new_pend;
  wire vec_wr;

  assign chan_sel = {chan_select_first, chan_select_second};
  assign wr_hit = wr_stb ? ctu_onehot({1'b0, chan_sel}) : 4'h0;
  // Vector byte: channel zero, no constant awaited, bit zero clear
  assign vec_wr = wr_hit[0] & ~tc_wait[0] & ~wr_data[`CTU_CW_IS_CTRL];
  assign new_pend = zero_ev & irq_en;

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `CTU_NUM_CH; gi = gi + 1) begin : g_ch
      reg [7:0] ctrl_ff;
      reg [7:0] tc_ff;
      reg [7:0] cnt_ff;
      reg tc_wait_ff;
      reg run_ff;
      reg armed_ff;
      reg trg_prev_ff;
      reg zero_ff;
      wire trg_lvl;
      wire trg_edge;
      wire ps_tick;
      wire counter_mode;
      wire dec;
      wire ps_clr;

      ctu_sync u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(count_trigger_input[gi]),
        .level_ff(trg_lvl)
      );

      // Prescaler runs only while timing
      ctu_prescale u_ps (
        .clk(clk),
        .srst(srst),
        .clr(ps_clr),
        .div256(ctrl_ff[`CTU_CW_DIV256]),
        .tick_ff(ps_tick)
      );

      assign counter_mode = ctrl_ff[`CTU_CW_COUNTER];
      assign trg_edge = ctrl_ff[`CTU_CW_RISING] ? (trg_lvl & ~trg_prev_ff) :
                        (~trg_lvl & trg_prev_ff);
      assign dec = run_ff & (counter_mode ? trg_edge : ps_tick);
      assign cnt_all[gi*8 +: 8] = cnt_ff;
      assign zero_ev[gi] = zero_ff;
      assign irq_en[gi] = ctrl_ff[`CTU_CW_IRQ_EN];
      assign ps_clr = ~run_ff | counter_mode;
      // Constant-pending flag, read by the vector decode
      assign tc_wait[gi] = tc_wait_ff;

      always @(posedge clk) begin
        if (srst) begin
          ctrl_ff <= `CTU_CTRL_RST;
          tc_ff <= `CTU_TC_RST;
          cnt_ff <= `CTU_TC_RST;
          tc_wait_ff <= 1'b0;
          run_ff <= 1'b0;
          armed_ff <= 1'b0;
          trg_prev_ff <= 1'b0;
          zero_ff <= 1'b0;
        end else begin
          trg_prev_ff <= trg_lvl;
          zero_ff <= 1'b0;
          if (dec) begin
            if (cnt_ff == 8'h01) begin
              cnt_ff <= tc_ff;
              zero_ff <= 1'b1;
            end else begin
              cnt_ff <= cnt_ff - 8'h01;
            end
          end
          if (armed_ff && trg_edge) begin
            armed_ff <= 1'b0;
            run_ff <= 1'b1;
          end
          if (wr_hit[gi]) begin
            if (tc_wait_ff) begin
              tc_ff <= wr_data;
              tc_wait_ff <= 1'b0;
              // Running channel keeps its count until zero
              if (!run_ff) begin
                cnt_ff <= wr_data;
                if (!counter_mode && ctrl_ff[`CTU_CW_TRIG_START]) begin
                  armed_ff <= 1'b1;
                end else begin
                  run_ff <= 1'b1;
                end
              end
            end else if (wr_data[`CTU_CW_IS_CTRL]) begin
              ctrl_ff <= wr_data;
              tc_wait_ff <= wr_data[`CTU_CW_TC_FOLLOWS];
              if (wr_data[`CTU_CW_SW_RESET]) begin
                run_ff <= 1'b0;
                armed_ff <= 1'b0;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Vector register, written through channel zero
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      vec_hi_ff <= `CTU_VEC_RST;
    end else if (vec_wr) begin
      vec_hi_ff <= wr_data[7:3];
    end
  end

  // ****************************************************************
  // Host read of the down-counters
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_stb;
      if (rd_stb) begin
        rd_data_ff <= cnt_all[chan_sel*8 +: 8];
      end
    end
  end

  // ****************************************************************
  // Zero-count pulse outputs, channels 0 to 2 only
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      zero_count_pulse_out_ff <= 3'h0;
    end else begin
      zero_count_pulse_out_ff <= zero_ev[`CTU_NUM_ZC-1:0];
    end
  end

  // ****************************************************************
  // Daisy-chain interrupt control
  // ****************************************************************
  reg [3:0] pend_ff;
  reg [3:0] serv_ff;
  wire [2:0] pend_idx;
  wire [2:0] serv_idx;
  wire grant_ok;
  wire [3:0] grant_oh;
  wire [3:0] ret_oh;
  wire req_now;

  assign pend_idx = ctu_first(pend_ff);
  assign serv_idx = ctu_first(serv_ff);
  // Lower priority may not interrupt a channel in service
  assign grant_ok = int_enable_in & ~pend_idx[2] & (pend_idx < serv_idx);
  assign grant_oh = (int_ack && grant_ok) ? ctu_onehot(pend_idx) : 4'h0;
  assign ret_oh = int_return ? ctu_onehot(serv_idx) : 4'h0;
  // Request drops at the acknowledge that takes it
  assign req_now = grant_ok & ~int_ack;

  always @(posedge clk) begin
    if (srst) begin
      pend_ff <= 4'h0;
      serv_ff <= 4'h0;
      int_req_n_ff <= 1'b1;
      int_enable_out_ff <= 1'b0;
    end else begin
      // New zero event wins over the acknowledge clear
      pend_ff <= (pend_ff & ~grant_oh) | new_pend;
      serv_ff <= (serv_ff & ~ret_oh) | grant_oh;
      int_req_n_ff <= ~req_now;
      int_enable_out_ff <= int_enable_in & ~|serv_ff & ~|pend_ff;
    end
  end

  // ****************************************************************
  // Vector output on a granted acknowledge
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      int_vector_ff <= 8'h00;
      int_vector_valid_ff <= 1'b0;
    end else begin
      int_vector_valid_ff <= int_ack & grant_ok;
      if (int_ack && grant_ok) begin
        int_vector_ff <= {vec_hi_ff, pend_idx[1:0], 1'b0};
      end
    end
  end
endmodule

// File: sim/ctu_checker.sv
// Port assertions for the counter/timer unit
`timescale 1ns/1ps
module ctu_checker (
  input wire clk,
  input wire srst,
  input wire rd_stb,
  input wire rd_valid_ff,
  input wire [2:0] zero_count_pulse_out_ff,
  input wire int_enable_in,
  input wire int_enable_out_ff,
  input wire int_req_n_ff,
  input wire int_ack,
  input wire [7:0] int_vector_ff,
  input wire int_vector_valid_ff
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_read;
    rd_stb ##1 rd_valid_ff;
  endsequence
  sequence s_grant;
    int_ack ##1 int_vector_valid_ff;
  endsequence
  a_read_valid_pulse: assert property (rd_stb |-> s_read)
    else $error("read valid missing");
  a_read_valid_cause: assert property (rd_valid_ff |-> $past(rd_stb))
    else $error("read valid without strobe");
  a_zero_single_pulse: assert property ((|zero_count_pulse_out_ff) |=>
    (zero_count_pulse_out_ff & $past(zero_count_pulse_out_ff)) == 3'h0)
    else $error("zero pulse too long");
  a_chain_blocks_out: assert property (!int_enable_in |=> !int_enable_out_ff)
    else $error("chain enable passed");
  a_req_needs_chain: assert property ($fell(int_req_n_ff) |-> $past(int_enable_in))
    else $error("request while chain blocked");
  a_vector_chan_word: assert property (int_vector_valid_ff |-> !int_vector_ff[0])
    else $error("vector bit zero set");
  a_vector_after_ack: assert property (int_vector_valid_ff |-> $past(int_ack))
    else $error("vector without ack");
  a_ack_gets_vector: assert property (
    (int_ack && !int_req_n_ff && int_enable_in) |-> s_grant)
    else $error("ack without vector");
  a_req_drops_grant: assert property (int_vector_valid_ff |-> int_req_n_ff)
    else $error("request held after grant");
endmodule

bind ctu_top ctu_checker i_ctu_checker (
  .clk(clk),
  .srst(srst),
  .rd_stb(rd_stb),
  .rd_valid_ff(rd_valid_ff),
  .zero_count_pulse_out_ff(zero_count_pulse_out_ff),
  .int_enable_in(int_enable_in),
  .int_enable_out_ff(int_enable_out_ff),
  .int_req_n_ff(int_req_n_ff),
  .int_ack(int_ack),
  .int_vector_ff(int_vector_ff),
  .int_vector_valid_ff(int_vector_valid_ff)
);

// File: sim/ctu_host_model.sv
// Host side interrupt service model
`timescale 1ns/1ps
module ctu_host_model (
  input wire clk,
  input wire srst,
  input wire int_req_n_ff,
  input wire [7:0] int_vector_ff,
  input wire int_vector_valid_ff,
  output reg int_ack,
  output reg int_return,
  output reg [7:0] last_vec,
  output reg [3:0] n_vec
);
  reg busy_ff;
  reg [4:0] wait_ff;
  always @(posedge clk) begin
    if (srst) begin
      {int_ack, int_return, busy_ff, last_vec, n_vec, wait_ff} <= 20'h0;
    end else begin
      int_ack <= 1'b0;
      int_return <= 1'b0;
      // One acknowledge per serviced request
      if (!busy_ff && !int_req_n_ff) begin
        int_ack <= 1'b1;
        busy_ff <= 1'b1;
      end
      if (int_vector_valid_ff) begin
        last_vec <= int_vector_ff;
        n_vec <= n_vec + 4'h1;
        wait_ff <= 5'h01;
      end else if (wait_ff != 5'h00) begin
        wait_ff <= wait_ff + 5'h01;
      end
      // Service ends, lower channels may follow
      if (wait_ff == 5'h14) begin
        int_return <= 1'b1;
        busy_ff <= 1'b0;
        wait_ff <= 5'h00;
      end
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the counter/timer unit
`timescale 1ns/1ps
module tb_top;
  reg clk, srst, cs_a, cs_b, wr_stb, rd_stb, ien;
  reg [7:0] wr_data;
  reg [3:0] trig;
  wire [7:0] rd_data, vec, last_vec;
  wire [2:0] zc;
  wire [3:0] n_vec;
  wire rd_valid, ieo, req_n, ack, vec_valid, ret;
  int n_mismatch, cmp_count, cyc, t_prev, g;
  reg [7:0] d;
  ctu_top i_ctu_top (.clk(clk), .srst(srst), .chan_select_first(cs_a),
    .chan_select_second(cs_b), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_data_ff(rd_data), .rd_valid_ff(rd_valid), .count_trigger_input(trig),
    .zero_count_pulse_out_ff(zc), .int_enable_in(ien), .int_enable_out_ff(ieo),
    .int_req_n_ff(req_n), .int_ack(ack), .int_vector_ff(vec),
    .int_vector_valid_ff(vec_valid), .int_return(ret));
  ctu_host_model i_ctu_host_model (.clk(clk), .srst(srst), .int_req_n_ff(req_n),
    .int_vector_ff(vec), .int_vector_valid_ff(vec_valid), .int_ack(ack),
    .int_return(ret), .last_vec(last_vec), .n_vec(n_vec));
  // ****
  // Clock, timeout and tasks
  // ****
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      $display("[ERR] timeout exp done got hang");
      test_done;
    end
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    cmp_count++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, v);
    end
  endtask
  task wr(input logic [1:0] c, input logic [7:0] b);
    @(posedge clk);
    #1 {cs_a, cs_b} = c;
    wr_data = b;
    wr_stb = 1;
    @(posedge clk);
    #1 wr_stb = 0;
  endtask
  task rd(input logic [1:0] c);
    @(posedge clk);
    #1 {cs_a, cs_b} = c;
    rd_stb = 1;
    @(posedge clk);
    #1 rd_stb = 0;
    chk("rd_valid", 1, rd_valid);
    d = rd_data;
  endtask
  task wz(input int ch);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (zc[ch] !== 1'b1 && k < 1000) begin
      @(posedge clk);
      #1 k++;
    end
    chk("zc_seen", 1, zc[ch]);
    g = cyc - t_prev;
    t_prev = cyc;
  endtask
  task wait_vec(input logic [3:0] n);
    int k;
    k = 0;
    while (n_vec !== n && k < 500) begin
      @(posedge clk);
      #1 k++;
    end
    chk("n_vec", n, n_vec);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {srst, cs_a, cs_b, wr_stb, rd_stb, ien} = 6'b100000;
    wr_data = 8'h00;
    trig = 4'h0;
    repeat (16) @(posedge clk);
    #1 srst = 0;
    chk("req_n", 1, req_n);
    wr(2'b00, 8'hd5);
    wr(2'b00, 8'h01);
    wr(2'b01, 8'hd5);
    wr(2'b01, 8'h01);
    wr(2'b00, 8'ha8);
    trig = 4'h3;
    repeat (12) @(posedge clk);
    #1 chk("req_blocked", 1, req_n);
    ien = 1;
    wait_vec(4'h1);
    chk("vec_ch0", 8'ha8, last_vec);
    wait_vec(4'h2);
    chk("vec_ch1", 8'haa, last_vec);
    chk("ieo_busy", 0, ieo);
    $display("test priority done");
    wr(2'b00, 8'h03);
    wr(2'b01, 8'h03);
    trig = 4'h0;
    wr(2'b00, 8'h05);
    wr(2'b00, 8'h03);
    wz(0);
    wz(0);
    chk("per16", 48, g);
    chk("ieo_idle", 1, ieo);
    rd(2'b00);
    chk("count", 8'h03, d);
    wz(0);
    chk("per_read", 48, g);
    wr(2'b00, 8'h05);
    wr(2'b00, 8'h05);
    wz(0);
    chk("per_old", 48, g);
    wz(0);
    chk("per_new", 80, g);
    $display("test timer16 done");
    wr(2'b10, 8'h25);
    wr(2'b10, 8'h02);
    wz(2);
    wz(2);
    chk("per256", 512, g);
    $display("test timer256 done");
    wr(2'b01, 8'h1d);
    wr(2'b01, 8'h01);
    repeat (40) @(posedge clk);
    #1 t_prev = cyc;
    trig = 4'h2;
    wz(1);
    chk("trig_start", 1, g >= 16 && g <= 30);
    $display("test trigger done");
    wr(2'b11, 8'h45);
    wr(2'b11, 8'h07);
    trig = 4'ha;
    repeat (8) @(posedge clk);
    #1 trig = 4'h2;
    repeat (8) @(posedge clk);
    rd(2'b11);
    chk("ch3_count", 8'h06, d);
    $display("test channel3 done");
    test_done;
  end
endmodule
